// File: bench/lfc_properties.sv
`timescale 1ns/1ps
module lfc_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_tready,
  input wire logic msg_tx_req,
  input wire logic msg_tx_ack,
  input wire logic [2:0] msg_tx_size_code,
  input wire logic msg_rx_tvalid,
  input wire logic msg_rx_tlast,
  input wire logic [15:0] msg_rx_tkeep,
  input wire logic pause_tx_req,
  input wire logic pause_tx_ack,
  input wire logic pause_rx_strobe,
  input wire logic [3:0] pause_rx_count
);
  // payload cycles still owed after an acknowledge
  logic [2:0] left_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left_r <= 3'h0;
    end else if (msg_tx_ack) begin
      left_r <= {1'h0, msg_tx_size_code[2:1]} + 3'h1;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_one(x);
    x ##1 !x;
  endsequence
  ack_cause_a: assert property (msg_tx_ack |-> $past(msg_tx_req) && left_r == 3'h0)
    else $error("ack without idle request");
  ack_pulse_a: assert property (msg_tx_ack |-> s_one(msg_tx_ack))
    else $error("ack not a pulse");
  ready_drop_a: assert property (msg_tx_ack |-> !tx_tready)
    else $error("ready high at ack");
  payload_hold_a: assert property (left_r != 3'h0 |-> !tx_tready)
    else $error("ready high in payload");
  pause_ack_a: assert property (pause_tx_ack |-> $past(pause_tx_req) ##0 s_one(pause_tx_ack))
    else $error("bad pause ack");
  rx_pulse_a: assert property (pause_rx_strobe |-> s_one(pause_rx_strobe))
    else $error("pause strobe too long");
  rx_count_a: assert property (!pause_rx_strobe |-> $stable(pause_rx_count))
    else $error("pause count moved");
  rx_last_a: assert property (msg_rx_tvalid |-> msg_rx_tlast)
    else $error("frame word without end marker");
  rx_keep_a: assert property (msg_rx_tvalid |-> msg_rx_tkeep[1:0] == 2'h3 &&
    ((msg_rx_tkeep + 16'h0001) & msg_rx_tkeep) == 16'h0000)
    else $error("bad keep");
endmodule

// File: bench/link_flow_control_if_tb_top.sv
`timescale 1ns/1ps
module link_flow_control_if_tb_top
  import lfc_pkg::*;
();
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic ltr = 1'h1;
  logic lpr = 1'h1;
  logic lrm = 1'h0;
  logic lrp = 1'h0;
  logic [127:0] lrd = '0;
  logic [2:0] lrs = 3'h0;
  logic [3:0] lrc = 4'h0;
  logic [31:0] ltd;
  logic ltv;
  logic [127:0] lmd;
  logic [2:0] lms;
  logic lmv;
  logic lpv;
  logic [3:0] lpc;
  logic [31:0] got;
  logic [31:0] rng = 32'h806b_a1a7;
  logic [159:0] q_tx[$], q_msg[$], q_pau[$], q_rxm[$], q_rxp[$];
  int err_count = 0;
  int check_count = 0;
  lfc_if fc_bus();
  always #50 clk = ~clk;
  lfc_core_end i_lfc_core_end (
    .clk(clk),
    .rstn(rstn),
    .fc(fc_bus),
    .link_tx_ready(ltr),
    .link_tx_data(ltd),
    .link_tx_valid(ltv),
    .link_msg_data(lmd),
    .link_msg_size(lms),
    .link_msg_valid(lmv),
    .link_pause_ready(lpr),
    .link_pause_valid(lpv),
    .link_pause_count(lpc),
    .link_rx_msg_valid(lrm),
    .link_rx_msg_data(lrd),
    .link_rx_msg_size(lrs),
    .link_rx_pause_valid(lrp),
    .link_rx_pause_count(lrc)
  );
  lfc_user_end i_lfc_user_end (
    .clk(clk),
    .rstn(rstn),
    .fc(fc_bus),
    .avs_address(adr),
    .avs_read(rd),
    .avs_write(wr),
    .avs_writedata(wd),
    .avs_readdata(rdat),
    .avs_waitrequest(wreq)
  );
  lfc_properties i_lfc_properties (
    .clk(clk),
    .rstn(rstn),
    .tx_tready(fc_bus.tx_tready),
    .msg_tx_req(fc_bus.msg_tx_req),
    .msg_tx_ack(fc_bus.msg_tx_ack),
    .msg_tx_size_code(fc_bus.msg_tx_size_code),
    .msg_rx_tvalid(fc_bus.msg_rx_tvalid),
    .msg_rx_tlast(fc_bus.msg_rx_tlast),
    .msg_rx_tkeep(fc_bus.msg_rx_tkeep),
    .pause_tx_req(fc_bus.pause_tx_req),
    .pause_tx_ack(fc_bus.pause_tx_ack),
    .pause_rx_strobe(fc_bus.pause_rx_strobe),
    .pause_rx_count(fc_bus.pause_rx_count)
  );
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [159:0] s, input logic [159:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      complete_run();
    end
  endtask
  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // {keep, data mask} for nb leading bytes
  function automatic logic [143:0] bmask(input int nb);
    logic [143:0] m;
    m = '0;
    for (int i = 0; i < nb; i++) begin
      m[i*8 +: 8] = 8'hff;
      m[128+i] = 1'h1;
    end
    return m;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    for (n = 0; n < 99; n++) begin
      @(posedge clk);
      if (wreq === 1'h0) break;
    end
    got = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
    tmo(n, 99);
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      if (q_tx.size() + q_msg.size() + q_pau.size() + q_rxm.size() + q_rxp.size() == 0) break;
    end
    tmo(n, 300);
  endtask
  always @(posedge clk) begin
    if (rstn === 1'h1) begin
      if (ltv === 1'h1) chk(ltd, q_tx.pop_front());
      if (lmv === 1'h1) chk({lms, lmd}, q_msg.pop_front());
      if (lpv === 1'h1) chk(lpc, q_pau.pop_front());
      if (fc_bus.pause_rx_strobe === 1'h1) chk(fc_bus.pause_rx_count, q_rxp.pop_front());
      if (fc_bus.msg_rx_tvalid === 1'h1) begin
        chk({fc_bus.msg_rx_tlast, fc_bus.msg_rx_tkeep, fc_bus.msg_rx_tdata}, q_rxm.pop_front());
      end
    end
  end
  initial begin
    logic [127:0] p;
    logic [143:0] m;
    logic [31:0] w;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    // normal word held off by link flow control
    @(posedge clk);
    ltr <= 1'h0;
    w = rnd();
    q_tx.push_back(w);
    bus(1'h1, LFC_REG_TXDATA, w);
    repeat (10) @(negedge clk);
    chk(q_tx.size(), 1);
    @(posedge clk);
    ltr <= 1'h1;
    drain();
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 4; k++) begin
        p[k*32 +: 32] = rnd();
        bus(1'h1, LFC_REG_PAY0 + 8'(4*k), p[k*32 +: 32]);
      end
      bus(1'h1, LFC_REG_CFG, 32'(c));
      m = bmask(2*c+2);
      q_msg.push_back({3'(c), p & m[127:0]});
      bus(1'h1, LFC_REG_CTRL, 32'h0000_0001);
      if (c == 7) begin
        q_tx.push_back(p[31:0]);
        bus(1'h1, LFC_REG_TXDATA, p[31:0]);
      end
      drain();
      if (c < 7) chk(fc_bus.tx_tready, 1'h1);
    end
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 32'h0 : (i == 1) ? 32'hf : rnd() & 32'hf;
      @(posedge clk);
      lpr <= 1'h0;
      q_pau.push_back(w);
      bus(1'h1, LFC_REG_CFG, w << 4);
      bus(1'h1, LFC_REG_CTRL, 32'h0000_0002);
      repeat (5) @(negedge clk);
      chk(q_pau.size(), 1);
      @(posedge clk);
      lpr <= 1'h1;
      drain();
    end
    for (int i = 0; i < 4; i++) begin
      w = rnd() & 32'hf;
      q_rxp.push_back(w);
      @(posedge clk);
      lrc <= w[3:0];
      lrp <= 1'h1;
      @(posedge clk);
      lrp <= 1'h0;
      lrc <= ~w[3:0];
    end
    drain();
    bus(1'h0, LFC_REG_STATUS, 32'h0);
    chk(got, {8'h04, 8'h00, 4'h0, w[3:0], 8'h00});
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 4; k++) p[k*32 +: 32] = rnd();
      m = bmask(2*c+2);
      q_rxm.push_back({1'h1, m[143:128], p & m[127:0]});
      @(posedge clk);
      lrd <= p;
      lrs <= 3'(c);
      lrm <= 1'h1;
      @(posedge clk);
      lrm <= 1'h0;
      lrd <= ~p;
    end
    drain();
    bus(1'h0, LFC_REG_RXKEEP, 32'h0);
    chk(got, {16'h0000, m[143:128]});
    complete_run();
  end
endmodule

// File: core/lfc_core_end.sv
`timescale 1ns/1ps
module lfc_core_end
  import lfc_pkg::*;
#(
  parameter lfc_build_t BUILD = LFC_FULL
) (
  input wire logic clk,
  input wire logic rstn,
  lfc_if.core_mp fc,
  // normal words toward the link
  input wire logic link_tx_ready,
  output logic [LFC_TX_W-1:0] link_tx_data,
  output logic link_tx_valid,
  // finished outgoing message
  output logic [LFC_MSG_W-1:0] link_msg_data,
  output logic [LFC_SIZE_W-1:0] link_msg_size,
  output logic link_msg_valid,
  // pause message toward the link
  input wire logic link_pause_ready,
  output logic link_pause_valid,
  output logic [LFC_PAUSE_W-1:0] link_pause_count,
  // received message from the link
  input wire logic link_rx_msg_valid,
  input wire logic [LFC_MSG_W-1:0] link_rx_msg_data,
  input wire logic [LFC_SIZE_W-1:0] link_rx_msg_size,
  // received pause from the link
  input wire logic link_rx_pause_valid,
  input wire logic [LFC_PAUSE_W-1:0] link_rx_pause_count
);
  typedef enum {LFC_TX_IDLE, LFC_TX_ACK, LFC_TX_PAY} lfc_txst_t;

  typedef struct packed {
    // message being filled
    lfc_txst_t st;
    logic [LFC_BEAT_W-1:0] beats;
    logic [1:0] widx;
    logic [LFC_SIZE_W-1:0] size;
    logic [LFC_MSG_W-1:0] mbuf;
    // handshakes toward the user
    logic msg_ack;
    logic tready;
    // words and messages toward the link
    logic [LFC_TX_W-1:0] ltx_data;
    logic ltx_valid;
    logic [LFC_MSG_W-1:0] lmsg_data;
    logic [LFC_SIZE_W-1:0] lmsg_size;
    logic lmsg_valid;
    // pause both ways
    logic pause_ack;
    logic lp_valid;
    logic [LFC_PAUSE_W-1:0] lp_count;
    logic prx_strobe;
    logic [LFC_PAUSE_W-1:0] prx_count;
  } lfc_core_state_t;

  // absent directions are tied off and never answer
  localparam logic HAS_TX = (BUILD != LFC_SIMPLEX_RX);
  localparam logic HAS_RX = (BUILD != LFC_SIMPLEX_TX);
  localparam logic HAS_PAUSE = (BUILD == LFC_FULL);

  lfc_core_state_t r;
  lfc_core_state_t n;

  always_comb begin
    n = r;
    // pulses fall unless set again below
    n.msg_ack = 1'b0;
    n.ltx_valid = 1'b0;
    n.lmsg_valid = 1'b0;
    n.pause_ack = 1'b0;
    n.lp_valid = 1'b0;
    n.prx_strobe = 1'b0;

    // normal data passes only on a ready and valid edge
    if (r.st == LFC_TX_IDLE && r.tready && fc.tx_tvalid) begin
      n.ltx_data = fc.tx_tdata;
      n.ltx_valid = 1'b1;
    end

    unique case (r.st)
      LFC_TX_IDLE: begin
        // registered: one more word may pass after link ready drops
        n.tready = HAS_TX & link_tx_ready;
        if (HAS_TX && fc.msg_tx_req) begin
          // size stays fixed for the whole message; the word count steps down once per payload word
          n.st = LFC_TX_ACK;
          n.msg_ack = 1'b1;
          n.tready = 1'b0;
          n.size = fc.msg_tx_size_code;
          n.beats = lfc_msg_beats(fc.msg_tx_size_code);
          n.widx = 2'h0;
          n.mbuf = '0;
        end
      end
      LFC_TX_ACK: begin
        // acknowledge cycle; payload starts in the next one
        n.st = LFC_TX_PAY;
        n.tready = 1'b0;
      end
      LFC_TX_PAY: begin
        // one word per cycle, no normal words until done; pause traffic still passes
        n.tready = 1'b0;
        n.mbuf[{r.widx, 5'h00} +: LFC_TX_W] = fc.tx_tdata;
        n.widx = r.widx + 2'h1;
        n.beats = r.beats - 3'h1;
        // last word taken: hand the message on, reopen normal data
        if (r.beats == 3'h1) begin
          n.st = LFC_TX_IDLE;
          n.lmsg_valid = 1'b1;
          n.lmsg_data = n.mbuf & lfc_byte_mask(lfc_msg_keep(r.size));
          n.lmsg_size = r.size;
          n.tready = link_tx_ready;
        end
      end
    endcase

    // pause request: one acknowledge per request
    // the ack blocks a second take of a request still held high
    if (HAS_PAUSE && fc.pause_tx_req && !r.pause_ack && link_pause_ready) begin
      n.pause_ack = 1'b1;
      n.lp_valid = 1'b1;
      n.lp_count = fc.pause_tx_count;
    end

    // one report pulse per arrival; count held until the next
    if (HAS_PAUSE && link_rx_pause_valid) begin
      n.prx_strobe = 1'b1;
      n.prx_count = link_rx_pause_count;
    end
  end

  // asynchronous clear; release is taken at the next clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r.st <= LFC_TX_IDLE;
      r.beats <= '0;
      r.widx <= '0;
      r.size <= '0;
      r.mbuf <= '0;
      r.msg_ack <= 1'b0;
      r.tready <= LFC_TREADY_RST;
      r.ltx_data <= '0;
      r.ltx_valid <= 1'b0;
      r.lmsg_data <= '0;
      r.lmsg_size <= '0;
      r.lmsg_valid <= 1'b0;
      r.pause_ack <= 1'b0;
      r.lp_valid <= 1'b0;
      r.lp_count <= '0;
      r.prx_strobe <= 1'b0;
      r.prx_count <= '0;
    end else begin
      r <= n;
    end
  end

  // received messages need no buffer: one word per message
  // simplex transmit builds hold the enable low
  lfc_msg_rx u_msg_rx (
    .clk(clk),
    .rstn(rstn),
    .en(HAS_RX),
    .in_valid(link_rx_msg_valid),
    .in_data(link_rx_msg_data),
    .in_size(link_rx_msg_size),
    .out_tvalid(fc.msg_rx_tvalid),
    .out_tlast(fc.msg_rx_tlast),
    .out_tkeep(fc.msg_rx_tkeep),
    .out_tdata(fc.msg_rx_tdata)
  );

  // toward the user
  assign fc.tx_tready = r.tready;
  assign fc.msg_tx_ack = r.msg_ack;
  assign fc.pause_tx_ack = r.pause_ack;
  assign fc.pause_rx_strobe = r.prx_strobe;
  assign fc.pause_rx_count = r.prx_count;

  // toward the link
  assign link_tx_data = r.ltx_data;
  assign link_tx_valid = r.ltx_valid;
  assign link_msg_data = r.lmsg_data;
  assign link_msg_size = r.lmsg_size;
  assign link_msg_valid = r.lmsg_valid;
  assign link_pause_valid = r.lp_valid;
  assign link_pause_count = r.lp_count;
endmodule

// File: core/lfc_if.sv
`timescale 1ns/1ps
interface lfc_if;
  import lfc_pkg::*;
  logic [LFC_TX_W-1:0] tx_tdata;
  logic tx_tvalid;
  logic tx_tready;
  logic msg_tx_req;
  logic msg_tx_ack;
  logic [LFC_SIZE_W-1:0] msg_tx_size_code;
  logic [LFC_MSG_W-1:0] msg_rx_tdata;
  logic msg_rx_tvalid;
  logic msg_rx_tlast;
  logic [LFC_MSG_BYTES-1:0] msg_rx_tkeep;
  logic pause_tx_req;
  logic pause_tx_ack;
  logic [LFC_PAUSE_W-1:0] pause_tx_count;
  logic pause_rx_strobe;
  logic [LFC_PAUSE_W-1:0] pause_rx_count;

  modport core_mp (
    input tx_tdata, tx_tvalid, msg_tx_req, msg_tx_size_code, pause_tx_req, pause_tx_count,
    output tx_tready, msg_tx_ack, msg_rx_tdata, msg_rx_tvalid, msg_rx_tlast, msg_rx_tkeep,
    output pause_tx_ack, pause_rx_strobe, pause_rx_count
  );
  modport user_mp (
    output tx_tdata, tx_tvalid, msg_tx_req, msg_tx_size_code, pause_tx_req, pause_tx_count,
    input tx_tready, msg_tx_ack, msg_rx_tdata, msg_rx_tvalid, msg_rx_tlast, msg_rx_tkeep,
    input pause_tx_ack, pause_rx_strobe, pause_rx_count
  );
endinterface

// File: core/lfc_msg_rx.sv
`timescale 1ns/1ps
module lfc_msg_rx
  import lfc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic in_valid,
  input wire logic [LFC_MSG_W-1:0] in_data,
  input wire logic [LFC_SIZE_W-1:0] in_size,
  output logic out_tvalid,
  output logic out_tlast,
  output logic [LFC_MSG_BYTES-1:0] out_tkeep,
  output logic [LFC_MSG_W-1:0] out_tdata
);
  typedef struct packed {
    logic valid;
    logic last;
    logic [LFC_MSG_BYTES-1:0] keep;
    logic [LFC_MSG_W-1:0] data;
  } lfc_rx_state_t;

  lfc_rx_state_t r;
  lfc_rx_state_t n;

  // whole message fits one word, so every frame is a single last word
  always_comb begin
    n = r;
    n.valid = en & in_valid;
    n.last = en & in_valid;
    n.keep = '0;
    if (en && in_valid) begin
      n.keep = lfc_msg_keep(in_size);
      n.data = in_data & lfc_byte_mask(lfc_msg_keep(in_size));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign out_tvalid = r.valid;
  assign out_tlast = r.last;
  assign out_tkeep = r.keep;
  assign out_tdata = r.data;
endmodule

// File: core/lfc_pkg.sv
package lfc_pkg;
  localparam int LFC_TX_BYTES = 4;
  localparam int LFC_TX_W = 32;
  localparam int LFC_MSG_BYTES = 16;
  localparam int LFC_MSG_W = 128;
  localparam int LFC_SIZE_W = 3;
  localparam int LFC_PAUSE_W = 4;
  localparam int LFC_BEAT_W = 3;

  typedef enum logic [1:0] {LFC_FULL, LFC_SIMPLEX_TX, LFC_SIMPLEX_RX} lfc_build_t;

  // register map of the user end, byte addresses
  localparam logic [7:0] LFC_REG_CTRL = 8'h00;
  localparam logic [7:0] LFC_REG_CFG = 8'h04;
  localparam logic [7:0] LFC_REG_TXDATA = 8'h08;
  localparam logic [7:0] LFC_REG_PAY0 = 8'h10;
  localparam logic [7:0] LFC_REG_STATUS = 8'h20;
  localparam logic [7:0] LFC_REG_RXD0 = 8'h30;
  localparam logic [7:0] LFC_REG_RXKEEP = 8'h40;
  localparam int LFC_CTRL_MSG_BIT = 0;
  localparam int LFC_CTRL_PAUSE_BIT = 1;
  localparam int LFC_CFG_SIZE_LSB = 0;
  localparam int LFC_CFG_PAUSE_LSB = 4;

  // values after reset
  localparam logic LFC_WAIT_RST = 1'h1;
  localparam logic LFC_TREADY_RST = 1'h0;
  localparam logic [31:0] LFC_RDATA_RST = 32'h0000_0000;

  // message length in bytes: two bytes per size step
  function automatic logic [4:0] lfc_msg_bytes(input logic [2:0] code);
    return {1'b0, code, 1'b0} + 5'h02;
  endfunction

  // data-port cycles needed to carry the message
  function automatic logic [2:0] lfc_msg_beats(input logic [2:0] code);
    return {1'b0, code[2:1]} + 3'h1;
  endfunction

  function automatic logic [15:0] lfc_msg_keep(input logic [2:0] code);
    logic [16:0] t;
    t = (17'h0_0001 << lfc_msg_bytes(code)) - 17'h0_0001;
    return t[15:0];
  endfunction

  function automatic logic [127:0] lfc_byte_mask(input logic [15:0] keep);
    logic [127:0] m;
    m = '0;
    for (int i = 0; i < LFC_MSG_BYTES; i++) begin
      m[i*8 +: 8] = {8{keep[i]}};
    end
    return m;
  endfunction
endpackage

// File: core/lfc_user_end.sv
`timescale 1ns/1ps
module lfc_user_end
  import lfc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  lfc_if.user_mp fc,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum {LFC_U_IDLE, LFC_U_REQ, LFC_U_PAY} lfc_ust_t;

  typedef struct packed {
    lfc_ust_t ust;
    logic msg_req;
    logic [LFC_SIZE_W-1:0] size;
    logic pause_req;
    logic [LFC_PAUSE_W-1:0] pause_cnt;
    logic [LFC_MSG_W-1:0] payload;
    logic [1:0] idx;
    logic [LFC_BEAT_W-1:0] beats;
    logic [LFC_TX_W-1:0] tdata;
    logic tvalid;
    logic [LFC_MSG_W-1:0] rx_data;
    logic [LFC_MSG_BYTES-1:0] rx_keep;
    logic [7:0] rx_msgs;
    logic [7:0] rx_pauses;
    logic [LFC_PAUSE_W-1:0] rx_pause_val;
    logic wait_r;
    logic [31:0] rdata;
  } lfc_user_state_t;

  lfc_user_state_t r;
  lfc_user_state_t n;
  logic msg_busy;
  logic stall;
  logic [31:0] rd_mux;

  always_comb begin
    n = r;
    msg_busy = (r.ust != LFC_U_IDLE);
    stall = 1'b0;
    rd_mux = 32'h0000_0000;

    unique case (r.ust)
      LFC_U_IDLE: begin
      end
      LFC_U_REQ: begin
        if (fc.msg_tx_ack) begin
          n.msg_req = 1'b0;
          n.tdata = r.payload[31:0];
          n.idx = 2'h1;
          n.beats = lfc_msg_beats(r.size) - 3'h1;
          n.ust = LFC_U_PAY;
        end
      end
      LFC_U_PAY: begin
        if (r.beats == 3'h0) begin
          n.ust = LFC_U_IDLE;
        end else begin
          n.tdata = r.payload[{r.idx, 5'h00} +: LFC_TX_W];
          n.idx = r.idx + 2'h1;
          n.beats = r.beats - 3'h1;
        end
      end
    endcase

    if (r.pause_req && fc.pause_tx_ack) begin
      n.pause_req = 1'b0;
    end
    if (r.tvalid && fc.tx_tready) begin
      n.tvalid = 1'b0;
    end
    // every valid word is captured at once
    if (fc.msg_rx_tvalid) begin
      n.rx_data = fc.msg_rx_tdata;
      n.rx_keep = fc.msg_rx_tlast ? fc.msg_rx_tkeep : r.rx_keep;
      n.rx_msgs = r.rx_msgs + 8'h01;
    end
    if (fc.pause_rx_strobe) begin
      n.rx_pause_val = fc.pause_rx_count;
      n.rx_pauses = r.rx_pauses + 8'h01;
    end

    // hold the bus while a new request would clash with one in flight
    if (avs_write && avs_address == LFC_REG_TXDATA) begin
      stall = r.tvalid | msg_busy;
    end
    if (avs_write && avs_address == LFC_REG_CTRL) begin
      stall = (avs_writedata[LFC_CTRL_MSG_BIT] & (msg_busy | r.tvalid))
            | (avs_writedata[LFC_CTRL_PAUSE_BIT] & r.pause_req);
    end
    if (avs_address[7:4] == LFC_REG_PAY0[7:4] && avs_write) begin
      stall = msg_busy;
    end
    // size and pause count must not move under a pending request
    if (avs_write && avs_address == LFC_REG_CFG) begin
      stall = r.pause_req | msg_busy;
    end

    if (avs_address == LFC_REG_CFG) begin
      rd_mux = {24'h00_0000, r.pause_cnt, 1'b0, r.size};
    end else if (avs_address == LFC_REG_TXDATA) begin
      rd_mux = r.tdata;
    end else if (avs_address[7:4] == LFC_REG_PAY0[7:4] && avs_address[1:0] == 2'h0) begin
      rd_mux = r.payload[{avs_address[3:2], 5'h00} +: 32];
    end else if (avs_address == LFC_REG_STATUS) begin
      rd_mux = {r.rx_pauses, r.rx_msgs, 4'h0, r.rx_pause_val, 5'h00, r.tvalid, r.pause_req, msg_busy};
    end else if (avs_address[7:4] == LFC_REG_RXD0[7:4] && avs_address[1:0] == 2'h0) begin
      rd_mux = r.rx_data[{avs_address[3:2], 5'h00} +: 32];
    end else if (avs_address == LFC_REG_RXKEEP) begin
      rd_mux = {16'h0000, r.rx_keep};
    end

    if (r.wait_r) begin
      if ((avs_read || avs_write) && !stall) begin
        n.wait_r = 1'b0;
        n.rdata = avs_read ? rd_mux : 32'h0000_0000;
      end
    end else begin
      n.wait_r = 1'b1;
      if (avs_write) begin
        if (avs_address == LFC_REG_CTRL) begin
          if (avs_writedata[LFC_CTRL_MSG_BIT]) begin
            n.ust = LFC_U_REQ;
            n.msg_req = 1'b1;
          end
          if (avs_writedata[LFC_CTRL_PAUSE_BIT]) begin
            n.pause_req = 1'b1;
          end
        end else if (avs_address == LFC_REG_CFG) begin
          n.size = avs_writedata[LFC_CFG_SIZE_LSB +: LFC_SIZE_W];
          n.pause_cnt = avs_writedata[LFC_CFG_PAUSE_LSB +: LFC_PAUSE_W];
        end else if (avs_address == LFC_REG_TXDATA) begin
          n.tdata = avs_writedata;
          n.tvalid = 1'b1;
        end else if (avs_address[7:4] == LFC_REG_PAY0[7:4] && avs_address[1:0] == 2'h0) begin
          n.payload[{avs_address[3:2], 5'h00} +: 32] = avs_writedata;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.ust <= LFC_U_IDLE;
      r.wait_r <= LFC_WAIT_RST;
      r.rdata <= LFC_RDATA_RST;
    end else begin
      r <= n;
    end
  end

  assign fc.msg_tx_req = r.msg_req;
  assign fc.msg_tx_size_code = r.size;
  assign fc.tx_tdata = r.tdata;
  assign fc.tx_tvalid = r.tvalid;
  assign fc.pause_tx_req = r.pause_req;
  assign fc.pause_tx_count = r.pause_cnt;
  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.wait_r;
endmodule
